// ===== tsr_defs.svh
// Constants for the temperature sensor two-wire register block.
// Assumes a 250 MHz system clock; included by tsr_pkg and tsr_top.
`ifndef TSR_DEFS_SVH
`define TSR_DEFS_SVH

// Register indices selected by the pointer
`define TSR_PTR_CAPABILITIES 3'h0
`define TSR_PTR_CONFIGURATION 3'h1
`define TSR_PTR_ALARM_UPPER 3'h2
`define TSR_PTR_ALARM_LOWER 3'h3
`define TSR_PTR_CRITICAL 3'h4
`define TSR_PTR_TEMPERATURE 3'h5
`define TSR_PTR_MAKER_ID 3'h6
`define TSR_PTR_PART_REV_ID 3'h7
`define TSR_PTR_RESET 3'h0
`define TSR_PTR_W 3

// Reset values
`define TSR_CAP_HIGH_GRADE 16'h002f
`define TSR_CAP_LOW_GRADE 16'h002d
`define TSR_RW_RESET 16'h0000
`define TSR_TEMP_RESET 16'h0000

// Device type codes in the upper address nibble
`define TSR_DTI_SENSOR 4'h3
`define TSR_DTI_MEMORY 4'ha
`define TSR_DTI_WPROT 4'h6

// Bus timeout
`define TSR_TMO_MIN_MS 25
`define TSR_TMO_MAX_MS 50
`define TSR_CLK_MHZ 250
`define TSR_TMO_CYCLES (`TSR_TMO_MIN_MS * `TSR_CLK_MHZ * 1000)
`define TSR_TMO_W 24

`endif

// ===== tsr_pkg.sv
// Types shared by the temperature sensor register block.
// Assumes tsr_defs.svh on the include path.
`default_nettype none

package tsr_pkg;
    `include "tsr_defs.svh"

    typedef enum logic [7:0] {
        TSR_IDLE   = 8'h01,
        TSR_ADDR   = 8'h02,
        TSR_PTR    = 8'h04,
        TSR_WDATA  = 8'h08,
        TSR_ACK    = 8'h10,
        TSR_RDATA  = 8'h20,
        TSR_MACK   = 8'h40,
        TSR_IGNORE = 8'h80
    } tsr_state_t;

    typedef struct packed {
        logic [15:0] sensor_configuration;
        logic [15:0] upper;
        logic [15:0] lower;
        logic [15:0] crit;
    } tsr_ctrl_t;

    typedef struct packed {
        logic strap_high;
        logic strap_mid;
        logic strap_low;
    } tsr_strap_t;

    typedef struct packed {
        tsr_state_t st;
        tsr_state_t after;
        logic [2:0] cnt;
        logic [7:0] sh;
        logic [7:0] wbuf;
        logic byte_ix;
        logic ack_on;
        logic ack_seen;
        logic oe;
        logic [`TSR_PTR_W-1:0] ptr;
        tsr_ctrl_t ctrl;
        logic [15:0] temp;
        logic [`TSR_TMO_W-1:0] tmo;
        logic scl_q;
        logic sda_q;
        logic tog_q;
        logic mem;
        logic wprot;
    } tsr_top_st_t;
endpackage : tsr_pkg

`default_nettype wire

// ===== tsr_sync.sv
// Two-stage synchroniser for a group of single-bit levels.
// Assumes each input is a level that stays for several clocks.
`default_nettype none

module tsr_sync import tsr_pkg::*; #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Levels
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } tsr_sync_st_t;

    tsr_sync_st_t s;
    tsr_sync_st_t next_s;

    if (WIDTH < 1) begin : g_width_chk
        $error("tsr_sync: WIDTH must be positive");
    end

    always_comb begin
        next_s.s1 = d;
        next_s.s2 = s.s1;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign q = s.s2;
endmodule : tsr_sync

`default_nettype wire

// ===== tsr_link_rx.sv
// Serial clock domain capture of the data line.
// Each rising clock edge stores the data bit and flips a toggle; the bit
// stays stable until the next rising edge, which the system side relies on.
`default_nettype none

module tsr_link_rx import tsr_pkg::*; (
    // Link clock and clear
    input wire logic scl_clk,
    input wire logic rst_async,
    // Pin
    input wire logic sda_in,
    // To system domain
    output logic bit_val,
    output logic bit_tog
);
    typedef struct packed {
        logic bit_val;
        logic tog;
    } tsr_link_st_t;

    tsr_link_st_t s;
    tsr_link_st_t next_s;

    always_comb begin
        next_s.bit_val = sda_in;
        next_s.tog = ~s.tog;
    end

    // Link clock may stand still, so clear without it
    always_ff @(posedge scl_clk or posedge rst_async) begin
        if (rst_async) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign bit_val = s.bit_val;
    assign bit_tog = s.tog;
endmodule : tsr_link_rx

`default_nettype wire

// ===== tsr_top.sv
// Two-wire slave front end and register map of a temperature sensor.
// Assumes SCL from the bus master, an open-drain data line resolved by the
// surroundings, and temperature samples from logic on CLK_SYS.
//
// Functional notes
// - Sensor answers to address 0011 plus strap levels; last bit is direction.
// - Address 1010 plus straps is decoded as a memory array access.
// - Address 0110 plus straps is decoded as a write-protect access.
// - Sensor transfers time out between 25 and 50 ms; memory not.
// - Device never holds the serial clock low.
// - Low three pointer bits select one of eight registers.
// - Register 0 is read-only capability word, grade dependent.
// - Register 1 is read/write configuration, cleared at reset.
// - Registers 2 to 4 hold alarm bounds and critical level, cleared.
// - Register 5 returns the latest measured temperature, read-only.
// - Register 6 returns a fixed maker identification code.
// - Register 7 returns a part and revision code per variant.
// - Pointer resets to register 0 and keeps last written value.
// - Write is address, pointer, then two data bytes, MSB first.
// - Read is address then two bytes; else pointer write and restart.
`default_nettype none

`include "tsr_defs.svh"

module tsr_top import tsr_pkg::*; #(
    parameter logic HIGH_GRADE = 1'b1,
    // Arbitrary identification values
    parameter logic [15:0] MAKER_ID = 16'h5a5a,
    parameter logic [15:0] PART_REV_ID = 16'ha5a5,
    parameter int TIMEOUT_CYCLES = `TSR_TMO_CYCLES
) (
    // System clock and reset
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    // Two-wire bus
    input wire logic SCL,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    // Address straps
    input wire tsr_strap_t STRAP,
    // Temperature samples
    input wire logic [15:0] TEMP_DATA,
    input wire logic TEMP_VALID,
    // Register contents and decode events
    output tsr_ctrl_t CTRL,
    output logic [`TSR_PTR_W-1:0] POINTER,
    output logic MEM_ACCESS,
    output logic WPROT_ACCESS
);
    localparam logic [15:0] CAP_VALUE = HIGH_GRADE ? `TSR_CAP_HIGH_GRADE
                                                   : `TSR_CAP_LOW_GRADE;
    localparam logic [`TSR_TMO_W-1:0] TMO_LAST =
        `TSR_TMO_W'(TIMEOUT_CYCLES - 1);

    if (TIMEOUT_CYCLES < 1 ||
        TIMEOUT_CYCLES >= (1 << `TSR_TMO_W)) begin : g_tmo_chk
        $error("tsr_top: TIMEOUT_CYCLES out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read decode

    function automatic logic [15:0] read_word(
        input logic [`TSR_PTR_W-1:0] p,
        input tsr_ctrl_t c,
        input logic [15:0] t
    );
        logic [15:0] w;
        w = 16'h0000;
        if (p == `TSR_PTR_CAPABILITIES) begin
            w = CAP_VALUE;
        end else if (p == `TSR_PTR_CONFIGURATION) begin
            w = c.sensor_configuration;
        end else if (p == `TSR_PTR_ALARM_UPPER) begin
            w = c.upper;
        end else if (p == `TSR_PTR_ALARM_LOWER) begin
            w = c.lower;
        end else if (p == `TSR_PTR_CRITICAL) begin
            w = c.crit;
        end else if (p == `TSR_PTR_TEMPERATURE) begin
            w = t;
        end else if (p == `TSR_PTR_MAKER_ID) begin
            w = MAKER_ID;
        end else begin
            w = PART_REV_ID;
        end
        return w;
    endfunction : read_word

    function automatic logic [7:0] read_byte(
        input logic [`TSR_PTR_W-1:0] p,
        input tsr_ctrl_t c,
        input logic [15:0] t,
        input logic low
    );
        logic [15:0] w;
        w = read_word(p, c, t);
        return low ? w[7:0] : w[15:8];
    endfunction : read_byte

    ////////////////////////////////////////////////////////////////////////
    // Crossings

    logic link_bit;
    logic link_tog;
    logic scl_s;
    logic sda_s;
    logic tog_s;
    tsr_strap_t strap_s;

    tsr_link_rx u_link (
        .scl_clk(SCL),
        .rst_async(SYS_RST),
        .sda_in(SDA_IN),
        .bit_val(link_bit),
        .bit_tog(link_tog)
    );

    tsr_sync #(
        .WIDTH(6)
    ) u_sync (
        .clk(CLK_SYS),
        .rst(SYS_RST),
        .d({SCL, SDA_IN, link_tog, STRAP}),
        .q({scl_s, sda_s, tog_s, strap_s})
    );

    ////////////////////////////////////////////////////////////////////////
    // Transfer engine

    tsr_top_st_t s;
    tsr_top_st_t next_s;

    logic bit_ev;
    logic fall;
    logic start;
    logic stop;
    logic [7:0] byte_in;
    logic [6:0] dev_sensor;
    logic [6:0] dev_mem;
    logic [6:0] dev_wprot;
    logic [7:0] rd;

    always_comb begin
        next_s = s;
        next_s.mem = 1'b0;
        next_s.wprot = 1'b0;
        next_s.scl_q = scl_s;
        next_s.sda_q = sda_s;
        next_s.tog_q = tog_s;
        // Toggle says a new bit stands stable in the link register
        bit_ev = tog_s != s.tog_q;
        fall = s.scl_q & ~scl_s;
        start = scl_s & s.scl_q & s.sda_q & ~sda_s;
        stop = scl_s & s.scl_q & ~s.sda_q & sda_s;
        byte_in = {s.sh[6:0], link_bit};
        dev_sensor = {`TSR_DTI_SENSOR, strap_s};
        dev_mem = {`TSR_DTI_MEMORY, strap_s};
        dev_wprot = {`TSR_DTI_WPROT, strap_s};
        rd = 8'h00;

        if (TEMP_VALID) begin
            next_s.temp = TEMP_DATA;
        end

        // Clock-low time is counted in every state except TSR_IDLE and TSR_IGNORE, so also during the address byte
        if (s.st == TSR_IDLE || s.st == TSR_IGNORE || scl_s) begin
            next_s.tmo = '0;
        end else begin
            next_s.tmo = s.tmo + `TSR_TMO_W'(1);
        end

        if (start) begin
            // Repeated start keeps the pointer
            next_s.st = TSR_ADDR;
            next_s.cnt = 3'h0;
            next_s.oe = 1'b0;
            next_s.ack_on = 1'b0;
            next_s.ack_seen = 1'b0;
        end else if (stop || s.tmo == TMO_LAST) begin
            next_s.st = TSR_IDLE;
            next_s.oe = 1'b0;
            next_s.ack_on = 1'b0;
            next_s.ack_seen = 1'b0;
            next_s.tmo = '0;
        end else begin
            case (s.st)
                TSR_ADDR, TSR_PTR, TSR_WDATA: begin
                    if (bit_ev) begin
                        next_s.sh = byte_in;
                        next_s.cnt = s.cnt + 3'h1;
                        if (s.cnt == 3'h7) begin
                            next_s.st = TSR_ACK;
                            if (s.st == TSR_ADDR) begin
                                next_s.byte_ix = 1'b0;
                                if (byte_in[7:1] == dev_sensor) begin
                                    next_s.after = byte_in[0] ? TSR_RDATA
                                                              : TSR_PTR;
                                end else begin
                                    next_s.st = TSR_IGNORE;
                                    next_s.mem = byte_in[7:1] == dev_mem;
                                    next_s.wprot =
                                        byte_in[7:1] == dev_wprot;
                                end
                            end else if (s.st == TSR_PTR) begin
                                // Upper pointer bits are dropped
                                next_s.ptr = byte_in[2:0];
                                next_s.after = TSR_WDATA;
                                next_s.byte_ix = 1'b0;
                            end else if (!s.byte_ix) begin
                                next_s.wbuf = byte_in;
                                next_s.byte_ix = 1'b1;
                                next_s.after = TSR_WDATA;
                            end else begin
                                next_s.after = TSR_IGNORE;
                                if (s.ptr == `TSR_PTR_CONFIGURATION) begin
                                    next_s.ctrl.sensor_configuration = {s.wbuf, byte_in};
                                end else if (s.ptr == `TSR_PTR_ALARM_UPPER) begin
                                    next_s.ctrl.upper = {s.wbuf, byte_in};
                                end else if (s.ptr == `TSR_PTR_ALARM_LOWER) begin
                                    next_s.ctrl.lower = {s.wbuf, byte_in};
                                end else if (s.ptr == `TSR_PTR_CRITICAL) begin
                                    next_s.ctrl.crit = {s.wbuf, byte_in};
                                end else begin
                                    next_s.ctrl = s.ctrl;
                                end
                            end
                        end
                    end
                end
                TSR_ACK: begin
                    if (bit_ev && s.ack_on) begin
                        next_s.ack_seen = 1'b1;
                    end
                    if (fall) begin
                        if (!s.ack_on) begin
                            next_s.oe = 1'b1;
                            next_s.ack_on = 1'b1;
                        end else if (s.ack_seen) begin
                            next_s.ack_on = 1'b0;
                            next_s.ack_seen = 1'b0;
                            next_s.st = s.after;
                            next_s.cnt = 3'h0;
                            next_s.oe = 1'b0;
                            if (s.after == TSR_RDATA) begin
                                rd = read_byte(s.ptr, s.ctrl, s.temp,
                                               s.byte_ix);
                                next_s.sh = rd;
                                next_s.oe = ~rd[7];
                            end
                        end
                    end
                end
                TSR_RDATA: begin
                    if (bit_ev) begin
                        next_s.sh = {s.sh[6:0], 1'b0};
                        next_s.cnt = s.cnt + 3'h1;
                        if (s.cnt == 3'h7) begin
                            next_s.st = TSR_MACK;
                        end
                    end else if (fall) begin
                        // Open drain: only a zero is driven
                        next_s.oe = ~s.sh[7];
                    end
                end
                TSR_MACK: begin
                    if (fall) begin
                        next_s.oe = 1'b0;
                    end
                    if (bit_ev) begin
                        if (!link_bit) begin
                            rd = read_byte(s.ptr, s.ctrl, s.temp,
                                           ~s.byte_ix);
                            next_s.byte_ix = ~s.byte_ix;
                            next_s.sh = rd;
                            next_s.cnt = 3'h0;
                            next_s.st = TSR_RDATA;
                        end else begin
                            next_s.st = TSR_IGNORE;
                        end
                    end
                end
                default: begin
                    next_s.oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            s <= '0;
            s.st <= TSR_IDLE;
            s.after <= TSR_IDLE;
            s.ptr <= `TSR_PTR_RESET;
            s.ctrl <= {4{`TSR_RW_RESET}};
            s.temp <= `TSR_TEMP_RESET;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    // No clock output exists, so the clock is never stretched
    assign SDA_OUT = 1'b0;
    assign SDA_OE = s.oe;
    assign CTRL = s.ctrl;
    assign POINTER = s.ptr;
    assign MEM_ACCESS = s.mem;
    assign WPROT_ACCESS = s.wprot;
endmodule : tsr_top

`default_nettype wire

// ===== tsr_top_asserts.sv
// Timing and register checks on the ports of tsr_top.
// Assumes binding into tsr_top; timeout figure passed from the design.
`default_nettype none

module tsr_top_asserts import tsr_pkg::*; #(
    parameter int TIMEOUT_CYCLES = 2000
) (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    // Bus
    input wire logic SCL,
    input wire logic SDA_OE,
    // Register view
    input wire tsr_ctrl_t CTRL,
    input wire logic [2:0] POINTER,
    input wire logic MEM_ACCESS,
    input wire logic WPROT_ACCESS
);
    int low_cnt;

    // Length of the current serial clock low phase
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST || SCL) begin
            low_cnt <= 0;
        end else if (low_cnt < TIMEOUT_CYCLES + 64) begin
            low_cnt <= low_cnt + 1;
        end
    end

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (SYS_RST);

    ////////////////////////////////////////////////////////////////////////
    reset_vals_a: assert property (
        $fell(SYS_RST) |-> !SDA_OE && POINTER == 3'h0 && CTRL == '0)
        else $error("Bad state after reset");
    oe_edge_a: assert property (
        $changed(SDA_OE) |-> !SCL && !$past(SCL, 2))
        else $error("Data line moved while clock high");
    tmo_release_a: assert property (
        low_cnt >= TIMEOUT_CYCLES + 8 |-> !SDA_OE)
        else $error("Data line held past timeout");
    tmo_early_a: assert property (
        $fell(SDA_OE) && low_cnt > 16 |-> low_cnt >= TIMEOUT_CYCLES)
        else $error("Timeout too early");
    ctrl_sel_a: assert property (
        $changed(CTRL) |-> SCL && POINTER inside {[3'h1:3'h4]})
        else $error("Register changed outside a write");
    sensor_configuration_sel_a: assert property (
        $changed(CTRL.sensor_configuration) |-> POINTER == 3'h1 && $stable(CTRL.crit))
        else $error("Configuration written through wrong pointer");
    crit_sel_a: assert property (
        $changed(CTRL.crit) |-> POINTER == 3'h4 && $stable(CTRL.upper))
        else $error("Critical level written through wrong pointer");
    mem_pulse_a: assert property (
        MEM_ACCESS |=> !MEM_ACCESS && !WPROT_ACCESS)
        else $error("Memory decode pulse too long");
    wprot_pulse_a: assert property (
        WPROT_ACCESS |=> !WPROT_ACCESS)
        else $error("Protect decode pulse too long");
endmodule : tsr_top_asserts

bind tsr_top tsr_top_asserts #(
    .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
) chk_u (
    .CLK_SYS(CLK_SYS),
    .SYS_RST(SYS_RST),
    .SCL(SCL),
    .SDA_OE(SDA_OE),
    .CTRL(CTRL),
    .POINTER(POINTER),
    .MEM_ACCESS(MEM_ACCESS),
    .WPROT_ACCESS(WPROT_ACCESS)
);

`default_nettype wire

// ===== tsr_master.sv
// Behavioural two-wire bus master paced by its own 15 ns link clock.
// Assumes a pulled-up data line resolved outside; clock idles high.
`default_nettype none

module tsr_master (
    // Pacing clock
    input wire logic clk,
    // Bus
    output logic scl,
    output logic sda_oe,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int H = 8;
    localparam int Q = 3;

    initial begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wt

    task automatic start();
        sda_oe = 1'b0;
        wt(H);
        scl = 1'b1;
        wt(H);
        sda_oe = 1'b1;
        wt(H);
        scl = 1'b0;
        wt(Q);
    endtask : start

    task automatic stop();
        sda_oe = 1'b1;
        wt(H);
        scl = 1'b1;
        wt(H);
        sda_oe = 1'b0;
        wt(H);
    endtask : stop

    // Eight data clocks then the acknowledge clock, MSB first
    task automatic byte_io(input logic [7:0] d, input logic mack,
                           output logic [7:0] r, output logic ack);
        logic [8:0] s;
        logic [8:0] g;
        s = {d, mack};
        for (int i = 8; i >= 0; i--) begin
            sda_oe = ~s[i];
            wt(H);
            scl = 1'b1;
            g[i] = sda;
            wt(H);
            scl = 1'b0;
            wt(Q);
        end
        r = g[8:1];
        ack = ~g[0];
    endtask : byte_io
endmodule : tsr_master

`default_nettype wire

// ===== tsr_top_tb.sv
// Self-checking bench for tsr_top driven through a bus master model.
// Assumes straps 101, so the sensor answers at 8'h3a and 8'h3b.
`default_nettype none

`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_mismatch++; \
    $display("[FAIL] %0t got %h want %h", $time, a, b); end end

module tsr_top_tb import tsr_pkg::*; ;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int TMO = 2000;
    // Timeout in link pacing ticks
    localparam int TMO_TICKS = TMO * 4 / 15;
    localparam logic [15:0] MK = 16'h3c96; // Arbitrary value
    localparam logic [15:0] PR = 16'h0c0d; // Arbitrary value
    logic clk, rst, scl, m_oe, sda, sda_out, sda_oe, tv, mem_acc, wp_acc;
    logic lclk;
    logic [15:0] td;
    logic [2:0] ptr;
    logic [7:0] rb;
    logic ok;
    tsr_strap_t strap;
    tsr_ctrl_t ctrl;
    int n_mismatch, tests_run, n_mem, n_wp;
    logic [15:0] ex [8] = '{16'h002f, 16'hc3a1, 16'hc3a2, 16'hc3a3,
        16'hc3a4, 16'h1a5c, MK, PR};
    logic [7:0] bad [6] = '{8'h38, 8'haa, 8'h6a, 8'ha8, 8'hab, 8'h4a};

    assign sda = !(m_oe || (sda_oe && !sda_out));

    tsr_master mst_u (.clk(lclk), .scl(scl), .sda_oe(m_oe), .sda(sda));

    tsr_top #(.HIGH_GRADE(1'b1), .MAKER_ID(MK), .PART_REV_ID(PR),
        .TIMEOUT_CYCLES(TMO)) dut_u (
        .CLK_SYS(clk), .SYS_RST(rst), .SCL(scl), .SDA_IN(sda),
        .SDA_OUT(sda_out), .SDA_OE(sda_oe), .STRAP(strap),
        .TEMP_DATA(td), .TEMP_VALID(tv), .CTRL(ctrl), .POINTER(ptr),
        .MEM_ACCESS(mem_acc), .WPROT_ACCESS(wp_acc));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial begin
        lclk = 1'b0;
        #0.7;
        forever #7.5 lclk = ~lclk;
    end

    always @(posedge clk) begin
        n_mem += (mem_acc === 1'b1);
        n_wp += (wp_acc === 1'b1);
    end

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude

    task automatic wr(input logic [2:0] p, input logic [15:0] d);
        logic [7:0] r;
        logic a0, a1, a2, a3;
        mst_u.start();
        mst_u.byte_io(8'h3a, 1'b1, r, a0);
        mst_u.byte_io({5'h00, p}, 1'b1, r, a1);
        mst_u.byte_io(d[15:8], 1'b1, r, a2);
        mst_u.byte_io(d[7:0], 1'b1, r, a3);
        mst_u.stop();
        `CHK({a0, a1, a2, a3}, 4'hf)
    endtask : wr

    task automatic rd(input logic set, input logic [2:0] p);
        logic [7:0] r, hi, lo;
        logic a0, a1, a2, x;
        a0 = 1'b1;
        a1 = 1'b1;
        mst_u.start();
        if (set) begin
            mst_u.byte_io(8'h3a, 1'b1, r, a0);
            mst_u.byte_io({5'h00, p}, 1'b1, r, a1);
            mst_u.start();
        end
        mst_u.byte_io(8'h3b, 1'b1, r, a2);
        mst_u.byte_io(8'hff, 1'b0, hi, x);
        mst_u.byte_io(8'hff, 1'b1, lo, x);
        mst_u.stop();
        `CHK({a0, a1, a2, hi, lo}, {3'h7, ex[p]})
    endtask : rd

    initial begin
        repeat (80000) @(posedge clk);
        n_mismatch++;
        conclude();
    end

    initial begin
        rst = 1'b1;
        tv = 1'b0;
        td = 16'h0000;
        strap = 3'b101;
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        `CHK({ptr, ctrl}, 67'h0)
        `CHK(sda_out, 1'b0)
        rd(1'b0, 3'h0);
        // Clock held low in mid-read
        mst_u.start();
        mst_u.byte_io(8'h3b, 1'b1, rb, ok);
        mst_u.wt(TMO_TICKS - 100);
        `CHK({ok, sda_oe}, 2'b11)
        mst_u.wt(150);
        `CHK(sda_oe, 1'b0)
        mst_u.stop();
        rd(1'b0, 3'h0);
        for (int i = 1; i < 5; i++) begin
            wr(3'(i), ex[i]);
        end
        `CHK(ctrl, {ex[1], ex[2], ex[3], ex[4]})
        wr(3'h0, 16'hffff);
        wr(3'h6, 16'h0000);
        `CHK(ctrl, {ex[1], ex[2], ex[3], ex[4]})
        @(posedge clk);
        #1;
        td = ex[5];
        tv = 1'b1;
        @(posedge clk);
        #1 tv = 1'b0;
        for (int i = 0; i < 8; i++) begin
            rd(1'b1, 3'(i));
        end
        rd(1'b0, 3'h7);
        `CHK(ptr, 3'h7)
        // Reset in mid-run with the bus idle
        @(posedge clk);
        #1 rst = 1'b1;
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        `CHK({ptr, ctrl}, 67'h0)
        rd(1'b0, 3'h0);
        foreach (bad[i]) begin
            mst_u.start();
            mst_u.byte_io(bad[i], 1'b1, rb, ok);
            mst_u.stop();
            mst_u.wt(20);
            `CHK(ok, 1'b0)
        end
        `CHK(n_mem, 2)
        `CHK(n_wp, 1)
        conclude();
    end
endmodule : tsr_top_tb

`default_nettype wire
